// File: wdtc_core.sv
// Watchdog timer core with APB control and write-protect unlock
//
// Contract
// R01: 18-bit up-counter on watchdog clock
// R02: Interval select codes pick 2^4..2^18 clocks
// R03: 1024-clock window after time-out allows clearing
// R04: Chip reset lasts 63 watchdog clocks
// R05: Enable zero stops and zeroes counter
// R06: Time-out sets flag; write one clears
// R07: Watchdog reset sets reset flag, write-one clears
// R08: Reset-enable zero: no reset, flag untouched
// R09: Reset function only while reset-enable set
// R10: Writing one to counter-clear zeroes counter
// R11: Counter-clear bit self-clears after counter reset
// R12: Time-out wake-up sets wake flag
// R13: Wake-enable gates power-down wake-up
// R14: Wake-up only from low-power RC clock
// R15: Debug acknowledge holds counter unless disabled
// R16: Control writes ignored unless unlocked by keys
// R17: Uncleared counter after window: flag and reset
// R18: Reset flag survives watchdog chip reset
// R19: Interrupt request equals flag AND enable
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module wdtc_core
#(
    parameter int SYNC_W = 2
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire wdtc_pkg::wdtc_apb_req_type apb_req,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    input  wire logic                       watchdog_clock,
    input  wire logic                       debug_ack,
    input  wire logic                       low_power_rc_clock,
    input  wire logic                       power_down,
    output logic                            timeout_irq,
    output logic                            wake_request,
    output logic                            chip_reset_out
);
    import wdtc_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (SYNC_W != 2)
        begin : g_bad
            $error("wdtc_core: SYNC_W must be 2");
        end
        if (SEL_BASE + SEL_STEP * 7 != CNT_W)
        begin : g_bad_span
            $error("wdtc_core: longest interval must fill the counter");
        end
        if ((1 << DELAY_W) != DELAY_CLKS)
        begin : g_bad_delay
            $error("wdtc_core: grace counter width must match the window");
        end
        if (RESET_CLKS >= (1 << RESET_W))
        begin : g_bad_reset
            $error("wdtc_core: reset counter too narrow");
        end
    endgenerate

    wdtc_ctrl_type        ctrl;
    wdtc_state_type       state;
    wdtc_key_type         key_step;
    logic                 unlocked;
    logic [CNT_W-1:0]     count;
    logic [DELAY_W-1:0]   grace_count;
    logic [RESET_W-1:0]   reset_count;
    logic [SYNC_W-1:0]    pins_sync;
    logic                 wclk_prev;
    logic                 tick;
    logic                 tick_run;
    logic                 timeout_hit;
    logic                 grace_done;
    logic                 fire_reset;
    logic                 reset_done;
    logic                 wake_hit;
    logic                 apb_setup;
    logic                 apb_fire;
    logic                 ctrl_write;
    logic                 unlock_write;
    logic                 clear_request;
    logic                 irq_clear;
    logic                 wake_clear;
    logic                 rflag_clear;
    logic [CNT_W-1:0]     limit;
    logic [31:0]          ctrl_word;

    // ************************************************************
    // Pin synchronisation and watchdog clock edge
    // ************************************************************
    wdtc_sync #(
        .WIDTH    (SYNC_W)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({debug_ack, watchdog_clock}),
        .sync_out (pins_sync)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wclk_prev <= 1'b0;
        else
            wclk_prev <= pins_sync[0];
    end

    // Each rising edge of the watchdog clock is one count step
    // Limitation: watchdog clock must stay well below a quarter of pclk
    assign tick     = pins_sync[0] & ~wclk_prev;
    assign tick_run = tick & ctrl.wd_enable
                      & ~(pins_sync[1] & ~ctrl.debug_hold_disable); // R15 R05

    // ************************************************************
    // Interval decode
    // ************************************************************
    function automatic logic [CNT_W-1:0] interval_limit(input logic [2:0] sel);
        logic [CNT_W:0] span;
        span = (CNT_W+1)'(1) << (SEL_BASE + SEL_STEP * int'(sel));
        return CNT_W'(span - (CNT_W+1)'(1));
    endfunction

    assign limit       = interval_limit(ctrl.interval_select); // R02
    assign timeout_hit = tick_run & (count == limit);
    assign grace_done  = tick_run & (state == ST_GRACE)
                         & (grace_count == DELAY_W'(DELAY_CLKS - 1)); // R03
    // A clear landing in the last tick of the window still saves the chip
    assign fire_reset  = grace_done & ctrl.wd_reset_enable
                         & ~ctrl.counter_clear; // R09 R17
    assign reset_done  = tick & (state == ST_RESET)
                         & (reset_count == RESET_W'(RESET_CLKS - 1)); // R04
    assign wake_hit    = timeout_hit & power_down & ctrl.wake_enable
                         & low_power_rc_clock; // R13 R14

    // ************************************************************
    // APB decode
    // ************************************************************
    assign apb_setup    = apb_req.psel & ~apb_req.penable;
    assign apb_fire     = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
    assign ctrl_write   = apb_fire & (apb_req.paddr == CTRL_OFFSET) & unlocked; // R16
    assign unlock_write = apb_fire & (apb_req.paddr == UNLOCK_OFFSET);

    // ************************************************************
    // Write-one requests, honoured only while unlocked
    // ************************************************************
    assign clear_request = ctrl_write & apb_req.pwdata[CLR_BIT]; // R10
    assign irq_clear     = ctrl_write & apb_req.pwdata[IF_BIT]; // R06
    assign wake_clear    = ctrl_write & apb_req.pwdata[WKF_BIT]; // R12
    assign rflag_clear   = ctrl_write & apb_req.pwdata[RF_BIT]; // R07

    assign ctrl_word = {ctrl.debug_hold_disable, 20'h00000, ctrl.interval_select,
                        ctrl.wd_enable, ctrl.timeout_irq_enable, ctrl.wake_flag,
                        ctrl.wake_enable, ctrl.timeout_irq_flag, ctrl.wd_reset_flag,
                        ctrl.wd_reset_enable, ctrl.counter_clear};

    // Zero wait states: answer is ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apb_setup;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (apb_setup)
            begin
                if (apb_req.paddr == CTRL_OFFSET)
                    prdata <= apb_req.pwrite ? 32'h0000_0000 : ctrl_word;
                else if (apb_req.paddr == UNLOCK_OFFSET)
                    prdata <= apb_req.pwrite ? 32'h0000_0000 : {31'h0, unlocked};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Write-protect unlock sequence
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_step <= KEY_WAIT1;
            unlocked <= 1'b0;
        end
        else if (unlock_write)
        begin
            key_step <= KEY_WAIT1;
            unlocked <= 1'b0;
            unique case (key_step)
                KEY_WAIT1:
                begin
                    if (apb_req.pwdata[7:0] == KEY_FIRST)
                        key_step <= KEY_WAIT2;
                end
                KEY_WAIT2:
                begin
                    if (apb_req.pwdata[7:0] == KEY_SECOND)
                        key_step <= KEY_WAIT3;
                end
                KEY_WAIT3:
                begin
                    if (apb_req.pwdata[7:0] == KEY_THIRD)
                        unlocked <= 1'b1; // R16
                end
            endcase
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= wdtc_ctrl_type'(CTRL_RESET[11:0] | 12'h000);
        else if (state == ST_RESET)
        begin
            // Chip reset restores control, reset flag survives
            if (reset_done)
            begin
                ctrl               <= wdtc_ctrl_type'(CTRL_RESET[11:0]);
                ctrl.wd_reset_flag <= 1'b1; // R18
            end
        end
        else
        begin
            if (ctrl_write)
            begin
                ctrl.debug_hold_disable <= apb_req.pwdata[DBG_BIT];
                ctrl.interval_select    <= apb_req.pwdata[SEL_HI:SEL_LO];
                ctrl.wd_enable          <= apb_req.pwdata[EN_BIT];
                ctrl.timeout_irq_enable <= apb_req.pwdata[IE_BIT];
                ctrl.wake_enable        <= apb_req.pwdata[WKE_BIT];
                ctrl.wd_reset_enable    <= apb_req.pwdata[RE_BIT];
            end
            // Counter-clear lives one cycle: set by write, dropped after zeroing
            ctrl.counter_clear <= clear_request; // R10 R11
            // Hardware set wins over a same-cycle write-one clear
            ctrl.timeout_irq_flag <= timeout_hit
                | (ctrl.timeout_irq_flag & ~irq_clear); // R06
            ctrl.wake_flag <= wake_hit
                | (ctrl.wake_flag & ~wake_clear); // R12
            ctrl.wd_reset_flag <= fire_reset
                | (ctrl.wd_reset_flag & ~rflag_clear); // R07 R08
        end
    end

    // ************************************************************
    // Free-running counter
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= '0;
        // Clear wins over a tick falling in the same cycle
        else if (!ctrl.wd_enable || ctrl.counter_clear || state == ST_RESET)
            count <= '0; // R05 R10
        else if (tick_run)
            count <= count + CNT_W'(1); // R01
    end

    // ************************************************************
    // Time-out, grace window and chip reset sequencing
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state       <= ST_RUN;
            grace_count <= '0;
            reset_count <= '0;
        end
        else
        begin
            unique case (state)
                ST_RUN:
                begin
                    grace_count <= '0;
                    reset_count <= '0;
                    if (timeout_hit && !ctrl.counter_clear)
                        state <= ST_GRACE; // R03
                end
                ST_GRACE:
                begin
                    // A repeat time-out here sets the flags again but leaves the state unchanged
                    if (!ctrl.wd_enable || ctrl.counter_clear)
                        state <= ST_RUN; // R03
                    else if (fire_reset)
                        state <= ST_RESET; // R17
                    else if (grace_done)
                        state <= ST_RUN; // R08 R09
                    else if (tick_run)
                        grace_count <= grace_count + DELAY_W'(1);
                end
                ST_RESET:
                begin
                    if (reset_done)
                        state <= ST_RUN;
                    else if (tick)
                        reset_count <= reset_count + RESET_W'(1); // R04
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_irq    <= 1'b0;
            wake_request   <= 1'b0;
            chip_reset_out <= 1'b0;
        end
        else
        begin
            timeout_irq    <= ctrl.timeout_irq_flag & ctrl.timeout_irq_enable; // R19 R06
            wake_request   <= wake_hit; // R13
            chip_reset_out <= fire_reset | ((state == ST_RESET) & ~reset_done); // R04
        end
    end
endmodule

// File: wdtc_pkg.sv
// Package of constants and types for the watchdog timer core
package wdtc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          APB_AW        = 12;
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] UNLOCK_OFFSET = 12'h100;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0700;

    // ************************************************************
    // Field positions of watchdog_control
    // ************************************************************
    localparam int DBG_BIT = 31;
    localparam int SEL_HI  = 10;
    localparam int SEL_LO  = 8;
    localparam int EN_BIT  = 7;
    localparam int IE_BIT  = 6;
    localparam int WKF_BIT = 5;
    localparam int WKE_BIT = 4;
    localparam int IF_BIT  = 3;
    localparam int RF_BIT  = 2;
    localparam int RE_BIT  = 1;
    localparam int CLR_BIT = 0;

    // ************************************************************
    // Timing in watchdog clocks
    // ************************************************************
    localparam int CNT_W      = 18;
    localparam int DELAY_CLKS = 1024;
    localparam int DELAY_W    = 10;
    localparam int RESET_CLKS = 63;
    localparam int RESET_W    = 6;
    localparam int SEL_BASE   = 4;
    localparam int SEL_STEP   = 2;

    // ************************************************************
    // Unlock key bytes
    // ************************************************************
    localparam logic [7:0] KEY_FIRST  = 8'h59;
    localparam logic [7:0] KEY_SECOND = 8'h16;
    localparam logic [7:0] KEY_THIRD  = 8'h88;

    typedef struct packed {
        logic       debug_hold_disable;
        logic [2:0] interval_select;
        logic       wd_enable;
        logic       timeout_irq_enable;
        logic       wake_flag;
        logic       wake_enable;
        logic       timeout_irq_flag;
        logic       wd_reset_flag;
        logic       wd_reset_enable;
        logic       counter_clear;
    } wdtc_ctrl_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } wdtc_apb_req_type;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_GRACE = 3'b010,
        ST_RESET = 3'b100
    } wdtc_state_type;

    typedef enum logic [2:0] {
        KEY_WAIT1 = 3'b001,
        KEY_WAIT2 = 3'b010,
        KEY_WAIT3 = 3'b100
    } wdtc_key_type;

endpackage

// File: wdtc_sync.sv
// Two-stage synchroniser for pins entering the pclk domain
`timescale 1ns/100ps
module wdtc_sync
#(
    parameter int WIDTH = 2
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    generate
        if (WIDTH < 1)
        begin : g_bad
            $error("wdtc_sync: WIDTH must be at least 1");
        end
        for (genvar i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

// File: wdtc_sva.sv
// Port-level checker for the watchdog timer core
`timescale 1ns/100ps
module wdtc_sva
    import wdtc_pkg::*;
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire wdtc_pkg::wdtc_apb_req_type apb_req,
    input wire logic                       pready,
    input wire logic [31:0]                prdata,
    input wire logic                       pslverr,
    input wire logic                       watchdog_clock,
    input wire logic                       debug_ack,
    input wire logic                       low_power_rc_clock,
    input wire logic                       power_down,
    input wire logic                       timeout_irq,
    input wire logic                       wake_request,
    input wire logic                       chip_reset_out
);
    logic [2:0] wd_sync;
    logic [7:0] rst_ticks;
    logic       ctrl_rd;

    // ************************************************************
    // Helper logic
    // ************************************************************
    // Own copy of the pin synchroniser, so the count may lag by one tick
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            wd_sync <= 3'h0;
        else
            wd_sync <= {wd_sync[1:0], watchdog_clock};

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            rst_ticks <= 8'h00;
        else if (!chip_reset_out)
            rst_ticks <= 8'h00;
        else if (wd_sync[1] && !wd_sync[2])
            rst_ticks <= rst_ticks + 8'h01;

    assign ctrl_rd = pready && !apb_req.pwrite && apb_req.paddr == CTRL_OFFSET;

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ************************************************************
    // Assertions
    // ************************************************************
    ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable |=> pready)
        else $error("pready missing after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    unmapped_err_a: assert property (pready && apb_req.paddr != CTRL_OFFSET
        && apb_req.paddr != UNLOCK_OFFSET |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    ctrl_ok_a: assert property (pready && apb_req.paddr == CTRL_OFFSET |-> !pslverr)
        else $error("error on control access");
    irq_level_a: assert property (ctrl_rd |-> timeout_irq == (prdata[IF_BIT] & prdata[IE_BIT]))
        else $error("interrupt differs from flag and enable");
    reset_length_a: assert property ($fell(chip_reset_out) |-> rst_ticks inside {[62:64]})
        else $error("chip reset length wrong");
    wake_gate_a: assert property (wake_request |-> $past(power_down) && $past(low_power_rc_clock))
        else $error("wake without power-down or low-power clock");
    wake_pulse_a: assert property (wake_request |=> !wake_request)
        else $error("wake request longer than one cycle");

    cover property ($rose(chip_reset_out));
    cover property (wake_request);
    cover property (pready && pslverr);
endmodule

// File: tb.sv
// Self-checking testbench for the watchdog timer core
`timescale 1ns/100ps
module tb;
    import wdtc_pkg::*;
    logic             pclk;
    logic             presetn;
    wdtc_apb_req_type req;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             watchdog_clock;
    logic             debug_ack;
    logic             low_power_rc_clock;
    logic             power_down;
    logic             timeout_irq;
    logic             wake_request;
    logic             chip_reset_out;
    logic [2:0]       phase;
    logic             woke;
    logic [32:0]      notes[$];
    logic [32:0]      note;
    int               ticks;
    int               t0;
    int               n;
    int               errors;
    int               comparisons;

    wdtc_core wdtc_core_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .watchdog_clock(watchdog_clock),
        .debug_ack(debug_ack), .low_power_rc_clock(low_power_rc_clock),
        .power_down(power_down), .timeout_irq(timeout_irq), .wake_request(wake_request),
        .chip_reset_out(chip_reset_out));

    // ************************************************************
    // Clocks and monitors
    // ************************************************************
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Watchdog clock at one eighth of pclk keeps the long counts short
    always @(posedge pclk)
    begin
        phase <= phase + 3'h1;
        watchdog_clock <= phase[2];
        if (phase == 3'h4)
            ticks <= ticks + 1;
        if (wake_request === 1'b1)
            woke <= 1'b1;
    end

    always @(posedge pclk)
        if (pready === 1'b1 && req.pwrite === 1'b0)
        begin
            note = notes.pop_front();
            check({31'h0, pslverr, prdata}, {31'h0, note});
        end

    // ************************************************************
    // Tasks
    // ************************************************************
    task check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        notes.push_back({err, exp});
        apb(1'b0, a, 32'h0);
    endtask

    task final_report;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        req = '0;
        presetn = 1'b0;
        debug_ack = 1'b0;
        low_power_rc_clock = 1'b1;
        power_down = 1'b1;
        phase = 3'h0;
        watchdog_clock = 1'b0;
        woke = 1'b0;
        ticks = 0;
        errors = 0;
        comparisons = 0;
        void'($urandom(49184));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_OFFSET, CTRL_RESET, 1'b0);
        rd(12'h800 | (12'($urandom) & 12'h7fc), 32'h0, 1'b1);
        apb(1'b1, CTRL_OFFSET, $urandom | 32'h80);
        rd(CTRL_OFFSET, CTRL_RESET, 1'b0);
        apb(1'b1, UNLOCK_OFFSET, {24'h0, KEY_FIRST});
        apb(1'b1, UNLOCK_OFFSET, {24'h0, KEY_SECOND});
        apb(1'b1, UNLOCK_OFFSET, {24'h0, KEY_THIRD});
        debug_ack <= 1'b1;
        apb(1'b1, CTRL_OFFSET, 32'h0000_00d0);
        repeat (320) @(posedge pclk);
        check(timeout_irq, 1'b0);
        debug_ack <= 1'b0;
        t0 = ticks;
        for (n = 0; n < 2000 && timeout_irq !== 1'b1; n++) @(posedge pclk);
        check(ticks - t0 >= 16 && ticks - t0 <= 17, 1'b1);
        rd(CTRL_OFFSET, 32'h0000_00f8, 1'b0);
        check(woke, 1'b1);
        // No reset expected: reset enable still clear
        repeat (8800) @(posedge pclk);
        check(chip_reset_out, 1'b0);
        rd(CTRL_OFFSET, 32'h0000_00f8, 1'b0);
        apb(1'b1, CTRL_OFFSET, 32'h0000_00b8);
        rd(CTRL_OFFSET, 32'h0000_0090, 1'b0);
        check(timeout_irq, 1'b0);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0183);
        rd(CTRL_OFFSET, 32'h0000_0182, 1'b0);
        // Clear inside the grace window must restart the whole sequence
        repeat (4000) @(posedge pclk);
        apb(1'b1, CTRL_OFFSET, 32'h0000_018b);
        t0 = ticks;
        for (n = 0; n < 20000 && chip_reset_out !== 1'b1; n++) @(posedge pclk);
        check(ticks - t0 >= 1088 && ticks - t0 <= 1089, 1'b1);
        t0 = ticks;
        for (n = 0; n < 2000 && chip_reset_out !== 1'b0; n++) @(posedge pclk);
        check(ticks - t0 >= 63 && ticks - t0 <= 64, 1'b1);
        rd(CTRL_OFFSET, 32'h0000_0704, 1'b0);
        final_report;
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        errors++;
        final_report;
    end
endmodule

bind wdtc_core wdtc_sva wdtc_sva_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .watchdog_clock(watchdog_clock),
    .debug_ack(debug_ack), .low_power_rc_clock(low_power_rc_clock), .power_down(power_down),
    .timeout_irq(timeout_irq), .wake_request(wake_request), .chip_reset_out(chip_reset_out));
